// ### logic/dlcr_regs.sv
// Contract
// - ldo_a voltage code lives in bits 4:0 at 40h, read/write, and sets its setpoint.
// - ldo_b voltage code lives in bits 4:0 at 41h, read/write, and sets its setpoint.
// - the code splits into a two-bit group and a three-bit step, 0.90 V to 3.30 V.
// - bit 5 of each control register enables that regulator independently.
// - bit 7 enables discharge to ground while that regulator is shut down.
// - bit 6 of the control registers and bits 7:2 at 43h are read-only.
// - bit 0 at 43h reads 1 in regulation and clears when the monitor sees low output.
// - bit 1 at 43h is a read/write fault mask, 0 masked and 1 not masked.
// - per factory sequence a low push button also enables ldo_a or ldo_b.
`timescale 1ns/10ps
`default_nettype none
module dlcr_regs #(
  parameter logic [4:0] LDO_A_CODE_DEFAULT = 5'h00,
  parameter logic [4:0] LDO_B_CODE_DEFAULT = 5'h00,
  parameter logic       LDO_A_EN_DEFAULT   = 1'b0,
  parameter logic       LDO_B_EN_DEFAULT   = 1'b0,
  parameter logic       PB_ENABLES_A       = 1'b0,
  parameter logic       PB_ENABLES_B       = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  // decoded serial register access, one cycle per byte
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // analog side
  input  wire logic       ldo_a_below_pok,
  input  wire logic       push_button_in_n,
  output logic      [8:0] ldo_a_setpoint,
  output logic      [8:0] ldo_b_setpoint,
  output logic            ldo_a_on,
  output logic            ldo_b_on,
  output logic            ldo_a_discharge,
  output logic            ldo_b_discharge,
  output logic            ldo_a_fault
);
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [4:0] ldo_a_voltage_code;
  logic [4:0] ldo_b_voltage_code;
  logic       ldo_a_enable_bit;
  logic       ldo_b_enable_bit;
  logic       ldo_a_discharge_enable;
  logic       ldo_b_discharge_enable;
  logic       ldo_a_fault_mask_n;
  logic       ldo_a_pok;
  logic       run_a;
  logic       run_b;
  logic       hit_a;
  logic       hit_b;
  logic       hit_s;
  logic [7:0] next_rdata;

  dlcr_code_if code_a ();
  dlcr_code_if code_b ();

  // reset release through two flops so removal is clean
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= dlcr_pkg::SYNC_RESET;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // address decode; host access only via this port
  assign hit_a = (reg_addr == dlcr_pkg::LDO_A_CONTROL_ADDR);
  assign hit_b = (reg_addr == dlcr_pkg::LDO_B_CONTROL_ADDR);
  assign hit_s = (reg_addr == dlcr_pkg::LDO_STATUS_ADDR);

  // ldo_a control fields; bit 6 has no storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_a_voltage_code     <= LDO_A_CODE_DEFAULT;
      ldo_a_enable_bit       <= LDO_A_EN_DEFAULT;
      ldo_a_discharge_enable <= 1'b0;
    end else if (reg_wr && hit_a) begin
      ldo_a_voltage_code     <= reg_wdata[dlcr_pkg::CODE_MSB:0];
      ldo_a_enable_bit       <= reg_wdata[dlcr_pkg::ENABLE_BIT];
      ldo_a_discharge_enable <= reg_wdata[dlcr_pkg::DISCH_BIT];
    end
  end

  // ldo_b control fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_b_voltage_code     <= LDO_B_CODE_DEFAULT;
      ldo_b_enable_bit       <= LDO_B_EN_DEFAULT;
      ldo_b_discharge_enable <= 1'b0;
    end else if (reg_wr && hit_b) begin
      ldo_b_voltage_code     <= reg_wdata[dlcr_pkg::CODE_MSB:0];
      ldo_b_enable_bit       <= reg_wdata[dlcr_pkg::ENABLE_BIT];
      ldo_b_discharge_enable <= reg_wdata[dlcr_pkg::DISCH_BIT];
    end
  end

  // fault mask is the only writable status bit; 7:2 and bit 0 ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_a_fault_mask_n <= dlcr_pkg::FMASK_RESET;
    end else if (reg_wr && hit_s) begin
      ldo_a_fault_mask_n <= reg_wdata[dlcr_pkg::FMASK_BIT];
    end
  end

  // power-ok follows the monitor one clock later; low output wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_a_pok <= 1'b0;
    end else begin
      ldo_a_pok <= ldo_a_on & ~ldo_a_below_pok;
    end
  end

  // push button joins the register enable when the sequence allows it
  assign run_a = ldo_a_enable_bit | (PB_ENABLES_A & ~push_button_in_n);
  assign run_b = ldo_b_enable_bit | (PB_ENABLES_B & ~push_button_in_n);

  assign code_a.code = ldo_a_voltage_code;
  assign code_b.code = ldo_b_voltage_code;

  dlcr_vdecode u_dec_a (
    .bus (code_a)
  );
  dlcr_vdecode u_dec_b (
    .bus (code_b)
  );

  // analog controls registered so outputs are glitch-free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_a_setpoint  <= '0;
      ldo_b_setpoint  <= '0;
      ldo_a_on        <= 1'b0;
      ldo_b_on        <= 1'b0;
      ldo_a_discharge <= 1'b0;
      ldo_b_discharge <= 1'b0;
    end else begin
      ldo_a_setpoint  <= code_a.setpoint;
      ldo_b_setpoint  <= code_b.setpoint;
      ldo_a_on        <= run_a;
      ldo_b_on        <= run_b;
      ldo_a_discharge <= ldo_a_discharge_enable & ~run_a;
      ldo_b_discharge <= ldo_b_discharge_enable & ~run_b;
    end
  end

  // device fault only when unmasked; power-ok clears regardless
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ldo_a_fault <= 1'b0;
    end else begin
      ldo_a_fault <= ldo_a_fault_mask_n & ldo_a_on & ldo_a_below_pok;
    end
  end

  // read mux; read-only bits return zero
  always_comb begin
    next_rdata = dlcr_pkg::RO_READ_VALUE;
    if (hit_a) begin
      next_rdata[dlcr_pkg::CODE_MSB:0]  = ldo_a_voltage_code;
      next_rdata[dlcr_pkg::ENABLE_BIT]  = ldo_a_enable_bit;
      next_rdata[dlcr_pkg::DISCH_BIT]   = ldo_a_discharge_enable;
    end else if (hit_b) begin
      next_rdata[dlcr_pkg::CODE_MSB:0]  = ldo_b_voltage_code;
      next_rdata[dlcr_pkg::ENABLE_BIT]  = ldo_b_enable_bit;
      next_rdata[dlcr_pkg::DISCH_BIT]   = ldo_b_discharge_enable;
    end else if (hit_s) begin
      next_rdata[dlcr_pkg::POK_BIT]     = ldo_a_pok;
      next_rdata[dlcr_pkg::FMASK_BIT]   = ldo_a_fault_mask_n;
    end
  end

  // read data lands one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= dlcr_pkg::RO_READ_VALUE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/dlcr_pkg.sv
package dlcr_pkg;
  // register map, byte addresses on the serial access port
  localparam logic [7:0] LDO_A_CONTROL_ADDR = 8'h40;
  localparam logic [7:0] LDO_B_CONTROL_ADDR = 8'h41;
  localparam logic [7:0] LDO_STATUS_ADDR    = 8'h43;
  // control register fields
  localparam int CODE_MSB    = 4;
  localparam int CODE_W      = 5;
  localparam int ENABLE_BIT  = 5;
  localparam int RO_CTRL_BIT = 6;
  localparam int DISCH_BIT   = 7;
  // status register fields
  localparam int POK_BIT     = 0;
  localparam int FMASK_BIT   = 1;
  // voltage code split: group in [4:3], step in [2:0]
  localparam int GROUP_LSB   = 3;
  localparam int STEP_W      = 3;
  // setpoint in units of 10 mV
  localparam int SETPT_W     = 9;
  localparam logic [7:0] RO_READ_VALUE = 8'h00;
  localparam logic [1:0] SYNC_RESET    = 2'h0;
  localparam logic       FMASK_RESET   = 1'b0;
endpackage

// ### logic/dlcr_code_if.sv
`timescale 1ns/10ps
`default_nettype none
// voltage code in, decoded setpoint out
interface dlcr_code_if;
  logic [4:0] code;
  logic [8:0] setpoint;
  modport decoder (input code, output setpoint);
  modport user    (output code, input setpoint);
endinterface
`default_nettype wire

// ### logic/dlcr_vdecode.sv
`timescale 1ns/10ps
`default_nettype none
// table lookup: group picks a row of eight steps; result in 10 mV units
module dlcr_vdecode (
  dlcr_code_if.decoder bus
);
  logic [1:0] group;
  logic [2:0] step;
  assign group = bus.code[4:dlcr_pkg::GROUP_LSB];
  assign step  = bus.code[dlcr_pkg::STEP_W-1:0];

  // four groups of eight steps, 0.90 V up to 3.30 V
  always_comb begin
    case ({group, step})
      5'h00: bus.setpoint = 9'h05A;
      5'h01: bus.setpoint = 9'h064;
      5'h02: bus.setpoint = 9'h06E;
      5'h03: bus.setpoint = 9'h078;
      5'h04: bus.setpoint = 9'h07D;
      5'h05: bus.setpoint = 9'h082;
      5'h06: bus.setpoint = 9'h087;
      5'h07: bus.setpoint = 9'h08C;
      5'h08: bus.setpoint = 9'h091;
      5'h09: bus.setpoint = 9'h096;
      5'h0A: bus.setpoint = 9'h09B;
      5'h0B: bus.setpoint = 9'h0A0;
      5'h0C: bus.setpoint = 9'h0AA;
      5'h0D: bus.setpoint = 9'h0AF;
      5'h0E: bus.setpoint = 9'h0B4;
      5'h0F: bus.setpoint = 9'h0B9;
      5'h10: bus.setpoint = 9'h0BE;
      5'h11: bus.setpoint = 9'h0C8;
      5'h12: bus.setpoint = 9'h0D2;
      5'h13: bus.setpoint = 9'h0DC;
      5'h14: bus.setpoint = 9'h0F0;
      5'h15: bus.setpoint = 9'h0FA;
      5'h16: bus.setpoint = 9'h104;
      5'h17: bus.setpoint = 9'h10E;
      5'h18: bus.setpoint = 9'h113;
      5'h19: bus.setpoint = 9'h118;
      5'h1A: bus.setpoint = 9'h11D;
      5'h1B: bus.setpoint = 9'h122;
      5'h1C: bus.setpoint = 9'h12C;
      5'h1D: bus.setpoint = 9'h136;
      5'h1E: bus.setpoint = 9'h140;
      5'h1F: bus.setpoint = 9'h14A;
      default: bus.setpoint = 9'h05A;
    endcase
  end
endmodule
`default_nettype wire

// ### verification/dlcr_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
// port-level checks on the register bank, one clock domain
module dlcr_regs_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       ldo_a_below_pok,
  input wire logic [8:0] ldo_a_setpoint,
  input wire logic       ldo_a_on,
  input wire logic       ldo_b_on,
  input wire logic       ldo_a_discharge,
  input wire logic       ldo_a_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // reads answer one cycle later, and only reads do
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  // read-only places read back as zero
  a_ctrl_ro_bit: assert property (reg_rvalid |-> !reg_rdata[6])
    else $error("bit 6 not zero");
  a_status_ro_bits: assert property (reg_rvalid &&
    $past(reg_addr) == 8'h43 |-> reg_rdata[7:2] == 6'h00)
    else $error("status upper bits not zero");
  // a low output seen the cycle before the read clears the power-ok bit
  a_pok_cleared: assert property (reg_rvalid &&
    $past(reg_addr) == 8'h43 && $past(ldo_a_below_pok, 2) |-> !reg_rdata[0])
    else $error("power-ok set while low");
  a_fault_cause: assert property (ldo_a_fault |-> $past(ldo_a_below_pok))
    else $error("fault without low output");
  a_dis_when_off: assert property (ldo_a_discharge |-> !ldo_a_on)
    else $error("discharge while running");
  // field writes reach the outputs two edges later
  a_enable_write: assert property (reg_wr && reg_addr == 8'h41
    |-> ##2 ldo_b_on == $past(reg_wdata[5], 2))
    else $error("enable write not applied");
  a_code_lowest: assert property (reg_wr && reg_addr == 8'h40 &&
    reg_wdata[4:0] == 5'h00 |-> ##2 ldo_a_setpoint == 9'h05A)
    else $error("lowest code wrong setpoint");
  c_fault: cover property (ldo_a_fault);
  c_discharge: cover property (ldo_a_discharge);
  c_pok_read: cover property (reg_rvalid && reg_rdata[0]);
endmodule
bind dlcr_regs dlcr_regs_props i_props (.clk(clk), .nrst(nrst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .ldo_a_below_pok(ldo_a_below_pok), .ldo_a_setpoint(ldo_a_setpoint),
  .ldo_a_on(ldo_a_on), .ldo_b_on(ldo_b_on),
  .ldo_a_discharge(ldo_a_discharge), .ldo_a_fault(ldo_a_fault));
`default_nettype wire

// ### verification/dlcr_host.sv
`timescale 1ns/10ps
`default_nettype none
// host side: single-byte accesses, address scrambled once released
module dlcr_host (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} <= 18'h0;
  // settings reach the device only as byte writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask
  // bounded wait for the answer so a dead port cannot hang us
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      ok = reg_rvalid === 1'b1;
      if (!ok) @(posedge clk);
    end
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, nrst = 1'b0, below = 1'b0, btn_n = 1'b1, fmask = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, a_on, b_on, a_dis, b_dis, a_flt;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [8:0] a_sp, b_sp;
  logic [7:0] ctl[2] = '{8'h00, 8'h1F};
  logic [31:0] r;
  bit ok;
  int miscompares = 0, n_checks = 0, seed = 65870;
  int volt[32] = '{90, 100, 110, 120, 125, 130, 135, 140, 145, 150, 155,
    160, 170, 175, 180, 185, 190, 200, 210, 220, 240, 250, 260, 270, 275,
    280, 285, 290, 300, 310, 320, 330};
  always #2.5 clk = ~clk;
  // button also runs ldo_a; ldo_b defaults to the top code
  dlcr_regs #(.LDO_B_CODE_DEFAULT(5'h1F), .PB_ENABLES_A(1'b1)) i_dlcr_regs (
    .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .ldo_a_below_pok(below),
    .push_button_in_n(btn_n), .ldo_a_setpoint(a_sp), .ldo_b_setpoint(b_sp),
    .ldo_a_on(a_on), .ldo_b_on(b_on), .ldo_a_discharge(a_dis),
    .ldo_b_discharge(b_dis), .ldo_a_fault(a_flt));
  dlcr_host i_dlcr_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // model keeps only writable bits
  task automatic put(input logic [7:0] a, input logic [7:0] v);
    i_dlcr_host.wr(a, v);
    if (a == 8'h40 || a == 8'h41) ctl[a[0]] = v & 8'hBF;
    if (a == 8'h43) fmask = v[1];
  endtask
  // outputs and all three registers against the model once settled
  task automatic settle;
    logic [1:0] run;
    repeat (3) @(posedge clk);
    #1;
    run = {ctl[1][5], ctl[0][5] | !btn_n};
    check(16'(a_sp), 16'(volt[ctl[0][4:0]]));
    check(16'(b_sp), 16'(volt[ctl[1][4:0]]));
    check(16'({a_on, b_on, a_dis, b_dis}), 16'({run[0], run[1],
      ctl[0][7] & !run[0], ctl[1][7] & !run[1]}));
    check(16'(a_flt), 16'(fmask & run[0] & below));
    for (int i = 0; i < 3; i++) begin
      i_dlcr_host.rd(i == 2 ? 8'h43 : 8'h40 + 8'(i), d, ok);
      check(16'({ok, d}), 16'({1'b1, i == 2 ? {6'h00, fmask, run[0] &
        !below} : ctl[i]}));
      if (!ok) stop_test;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    settle;
    $display("test defaults done");
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      put(8'h40 | 8'(i & 1), {r[7:5], 5'(i >> 1)});
      settle;
    end
    $display("test codes done");
    put(8'h40, 8'h25);
    put(8'h43, 8'hFF);
    settle;
    @(posedge clk) below <= 1'b1;
    settle;
    put(8'h43, 8'h00);
    settle;
    @(posedge clk) below <= 1'b0;
    put(8'h42, 8'hFF);
    i_dlcr_host.rd(8'h42, d, ok);
    check(16'({ok, d}), 16'h0100);
    $display("test status done");
    put(8'h40, 8'h80);
    @(posedge clk) btn_n <= 1'b0;
    settle;
    @(posedge clk) btn_n <= 1'b1;
    settle;
    $display("test button done");
    stop_test;
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
